// [design/stt_timer.sv]
// standard ten-bit timer: registers, counter, comparators and pin logic
`timescale 1ns/10ps
module stt_timer
	import stt_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic high_speed_clock_tick_i,
	input wire logic time_base_clock_tick_i,
	input wire logic external_clock_pin_i,
	input wire logic timer_io_pin_i,
	output logic timer_io_pin_o,
	output logic timer_io_pin_oe_o,
	output logic timer_powered_o,
	output logic compare_a_flag_o,
	output logic compare_p_flag_o
);
	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [9:0] cnt_r;
	logic [9:0] compare_a_value_r;
	logic [1:0] stat_r;
	logic [7:0] rdata_r;
	logic lvl_r;
	logic pin_r;
	logic oe_r;
	logic sp_r;
	logic a_pulse_r;
	logic p_pulse_r;
	logic ext_prev_r;
	logic io_prev_r;
	logic [1:0] pins_s;
	logic on_w;
	logic pau_w;
	logic [2:0] cksel_w;
	logic [2:0] rp_w;
	logic [1:0] mode_w;
	logic [1:0] io_w;
	logic oc_w;
	logic pol_w;
	logic dpx_w;
	logic cclr_w;
	logic cnt_tick;
	logic cnt_step;
	logic on_rise;
	logic [10:0] cnt_inc;
	logic [10:0] p_end;
	logic [10:0] a_end;
	logic [10:0] duty;
	logic p_hit;
	logic a_hit;
	logic clr_now;
	logic a_ev;
	logic p_ev;
	logic cap_ev;
	logic cmp_like;
	logic pwm_act;
	logic pwm_sel;

	assign on_w = ctrl0_r[STT_C0_ON];
	assign pau_w = ctrl0_r[STT_C0_PAU];
	assign cksel_w = ctrl0_r[STT_C0_CK_LSB +: 3];
	assign rp_w = ctrl0_r[STT_C0_RP_LSB +: 3];
	assign mode_w = ctrl1_r[STT_C1_M_LSB +: 2];
	assign io_w = ctrl1_r[STT_C1_IO_LSB +: 2];
	assign oc_w = ctrl1_r[STT_C1_OC];
	assign pol_w = ctrl1_r[STT_C1_POL];
	assign dpx_w = ctrl1_r[STT_C1_DPX];
	assign cclr_w = ctrl1_r[STT_C1_CCLR];
	assign cmp_like = (mode_w == STT_M_CMP) || (mode_w == STT_M_TC);

	// bit 0 is the external clock pin, bit 1 the timer pin as capture input
	stt_sync #(
		.WIDTH(2)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i({timer_io_pin_i, external_clock_pin_i}),
		.sync_o(pins_s)
	);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ext_prev_r <= 1'b0;
			io_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= pins_s[0];
			io_prev_r <= pins_s[1];
		end
	end

	stt_clk_sel u_clk_sel (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.clock_select_i(cksel_w),
		.high_speed_tick_i(high_speed_clock_tick_i),
		.time_base_tick_i(time_base_clock_tick_i),
		.ext_rise_i(pins_s[0] && !ext_prev_r),
		.ext_fall_i(!pins_s[0] && ext_prev_r),
		.tick_o(cnt_tick)
	);

	assign on_rise = reg_wr_i && (reg_addr_i == STT_ADR_CTRL0) && reg_wdata_i[STT_C0_ON] && !on_w;
	assign cnt_step = on_w && !pau_w && cnt_tick;
	assign cnt_inc = {1'b0, cnt_r} + 11'h001;
	// a zero period field means a full 1024-clock wrap
	assign p_end = {(rp_w == 3'h0), rp_w, 7'h00};
	assign a_end = {1'b0, compare_a_value_r};
	assign p_hit = cnt_step && (cnt_inc == p_end);
	assign a_hit = cnt_step && (compare_a_value_r != 10'h000) && (cnt_inc == a_end);

	always_comb begin
		clr_now = 1'b0;
		a_ev = 1'b0;
		p_ev = 1'b0;
		if (cmp_like) begin
			clr_now = cclr_w ? a_hit : p_hit;
			a_ev = a_hit;
			p_ev = !cclr_w && p_hit;
		end else if (mode_w == STT_M_PWM) begin
			clr_now = dpx_w ? a_hit : p_hit;
			a_ev = a_hit;
			p_ev = p_hit;
		end else begin
			a_ev = cap_ev;
		end
	end

	// counter has no software write path, only the on/off rising edge
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_r <= STT_CNT_RST;
		end else if (on_rise) begin
			cnt_r <= STT_CNT_RST;
		end else if (cnt_step) begin
			cnt_r <= clr_now ? STT_CNT_RST : cnt_inc[9:0];
		end
	end

	always_comb begin
		cap_ev = 1'b0;
		if (on_w && (mode_w == STT_M_CAP)) begin
			unique case (io_w)
				2'h0: cap_ev = pins_s[1] && !io_prev_r;
				2'h1: cap_ev = !pins_s[1] && io_prev_r;
				2'h2: cap_ev = pins_s[1] != io_prev_r;
				2'h3: cap_ev = 1'b0;
			endcase
		end
	end

	// capture takes priority over a software write in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			compare_a_value_r <= STT_COMPARE_A_VALUE_RST;
		end else if (cap_ev) begin
			compare_a_value_r <= cnt_r;
		end else if (reg_wr_i && (reg_addr_i == STT_ADR_CCRAL)) begin
			compare_a_value_r[7:0] <= reg_wdata_i;
		end else if (reg_wr_i && (reg_addr_i == STT_ADR_CCRAH)) begin
			compare_a_value_r[9:8] <= reg_wdata_i[1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl0_r <= STT_CTRL0_RST;
			ctrl1_r <= STT_CTRL1_RST;
		end else if (reg_wr_i && (reg_addr_i == STT_ADR_CTRL0)) begin
			ctrl0_r <= reg_wdata_i;
		end else if (reg_wr_i && (reg_addr_i == STT_ADR_CTRL1)) begin
			ctrl1_r <= reg_wdata_i;
		end
	end

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			stat_r <= 2'h0;
			a_pulse_r <= 1'b0;
			p_pulse_r <= 1'b0;
		end else begin
			a_pulse_r <= a_ev;
			p_pulse_r <= p_ev;
			if (a_ev) begin
				stat_r[STT_ST_AF] <= 1'b1;
			end else if (reg_wr_i && (reg_addr_i == STT_ADR_STAT) && reg_wdata_i[STT_ST_AF]) begin
				stat_r[STT_ST_AF] <= 1'b0;
			end
			if (p_ev) begin
				stat_r[STT_ST_PF] <= 1'b1;
			end else if (reg_wr_i && (reg_addr_i == STT_ADR_STAT) && reg_wdata_i[STT_ST_PF]) begin
				stat_r[STT_ST_PF] <= 1'b0;
			end
		end
	end

	// duty at or above the period never goes inactive inside the period
	assign duty = dpx_w ? p_end : a_end;
	assign pwm_act = {1'b0, cnt_r} < duty;

	always_comb begin
		unique case (io_w)
			2'h0: pwm_sel = 1'b0;
			2'h1: pwm_sel = 1'b1;
			2'h2: pwm_sel = pwm_act;
			2'h3: pwm_sel = sp_r;
		endcase
	end

	// single pulse opens on the on/off rising edge and closes at an A match
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sp_r <= 1'b0;
		end else if (on_rise) begin
			sp_r <= 1'b1;
		end else if (a_hit || !on_w) begin
			sp_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lvl_r <= 1'b0;
		end else if (mode_w == STT_M_CMP) begin
			if (on_rise) begin
				lvl_r <= oc_w;
			end else if (a_hit) begin
				unique case (io_w)
					2'h0: lvl_r <= lvl_r;
					2'h1: lvl_r <= oc_w ? 1'b0 : lvl_r;
					2'h2: lvl_r <= oc_w ? lvl_r : 1'b1;
					2'h3: lvl_r <= !lvl_r;
				endcase
			end
		end else if (mode_w == STT_M_PWM) begin
			lvl_r <= oc_w ? pwm_sel : !pwm_sel;
		end
	end

	// the pin stays undriven in timer and capture modes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pin_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			pin_r <= lvl_r ^ pol_w;
			oe_r <= (mode_w == STT_M_CMP) || (mode_w == STT_M_PWM);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				STT_ADR_CTRL0: rdata_r <= ctrl0_r;
				STT_ADR_CTRL1: rdata_r <= ctrl1_r;
				STT_ADR_CNTL: rdata_r <= cnt_r[7:0];
				STT_ADR_CNTH: rdata_r <= {6'h00, cnt_r[9:8]};
				STT_ADR_CCRAL: rdata_r <= compare_a_value_r[7:0];
				STT_ADR_CCRAH: rdata_r <= {6'h00, compare_a_value_r[9:8]};
				STT_ADR_STAT: rdata_r <= {6'h00, stat_r};
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata_o = rdata_r;
	assign timer_io_pin_o = pin_r;
	assign timer_io_pin_oe_o = oe_r;
	assign timer_powered_o = on_w;
	assign compare_a_flag_o = a_pulse_r;
	assign compare_p_flag_o = p_pulse_r;

	sequence s_stay_off;
		!on_w ##1 !on_w;
	endsequence

	sequence s_stay_paused;
		(on_w && pau_w) ##1 (on_w && pau_w);
	endsequence

	property p_count_up;
		@(posedge core_clk_i) disable iff (rst_i)
		cnt_step && !clr_now |=> cnt_r == $past(cnt_r) + 10'h001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter missed an increment");

	property p_on_clear;
		@(posedge core_clk_i) disable iff (rst_i)
		on_rise |=> (cnt_r == STT_CNT_RST) && on_w;
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("on edge did not clear counter");

	property p_off_hold;
		@(posedge core_clk_i) disable iff (rst_i)
		s_stay_off |-> $stable(cnt_r) && !timer_powered_o;
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("counter moved while off");

	property p_pause_hold;
		@(posedge core_clk_i) disable iff (rst_i)
		s_stay_paused |-> $stable(cnt_r);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("counter moved while paused");

	property p_no_clock;
		@(posedge core_clk_i) disable iff (rst_i)
		(cksel_w == STT_CK_NONE) |-> !cnt_step;
	endproperty
	a_no_clock: assert property (p_no_clock) else $error("undefined source clocked counter");

	property p_init_level;
		@(posedge core_clk_i) disable iff (rst_i)
		on_rise && (mode_w == STT_M_CMP) |=> lvl_r == $past(oc_w)
			##1 timer_io_pin_o == ($past(lvl_r) ^ $past(pol_w));
	endproperty
	a_init_level: assert property (p_init_level) else $error("compare start level wrong");

	property p_tc_undriven;
		@(posedge core_clk_i) disable iff (rst_i)
		(mode_w == STT_M_TC) ##1 (mode_w == STT_M_TC) |-> !timer_io_pin_oe_o;
	endproperty
	a_tc_undriven: assert property (p_tc_undriven) else $error("pin driven in timer mode");

	property p_match_clear;
		@(posedge core_clk_i) disable iff (rst_i)
		cnt_step && clr_now |=> (cnt_r == STT_CNT_RST) && (compare_a_flag_o || compare_p_flag_o);
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("match clear wrong");

	property p_a_only;
		@(posedge core_clk_i) disable iff (rst_i)
		cmp_like && cclr_w |-> !p_ev ##1 !compare_p_flag_o || $past(p_ev);
	endproperty
	a_a_only: assert property (p_a_only) else $error("P flag raised with A clearing");

	property p_capture;
		@(posedge core_clk_i) disable iff (rst_i)
		cap_ev |=> (compare_a_value_r == $past(cnt_r)) && stat_r[STT_ST_AF] && compare_a_flag_o;
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not latch counter");
endmodule : stt_timer

// [common/stt_pkg.sv]
// constants, field positions and codes of the standard ten-bit timer
// Behaviour
// - ten-bit up counter advances once per selected timer clock edge
// - comparator P checks counter bits 9..7, comparator A all ten bits
// - no software write to counter; on/off rising edge clears it
// - on/off low stops counting and powers down; value is kept
// - pause high holds count while powered; release resumes from held value
// - clock select picks sys/4, sys, high/16, high/64, time base, pin edges
// - clock select code 101 feeds no clock, counter stands still
// - compare mode: on/off rising edge restores the initial output level
// - period field n gives n*128 clocks, zero gives 1024 clocks
// - mode field: compare, capture, pwm/single pulse, timer; timer drives no pin
// - compare mode A match: keep, drive low, drive high or toggle pin
// - pwm mode output: forced inactive, forced active, pwm wave, single pulse
// - capture trigger: rising, falling, both edges or disabled
// - initial level bit: compare start level, pwm active level, unused in timer
// - compare match requesting the initial level leaves the pin unchanged
// - polarity bit inverts the pin, no effect in timer mode
// - role swap bit exchanges period and duty roles of P and A
// - clear source: A match, or P match / overflow when period is zero
// - clear source bit ignored in pwm, single pulse and capture modes
// - counter clear by overflow or match raises a timer flag, except the 1023 wrap in capture mode or with A clearing and A zero
// - compare mode with A clearing raises only the A flag
// - pwm duty at or above period keeps output active the whole period
// - pwm mode raises separate A and P flags on each match
package stt_pkg;
	localparam int unsigned STT_CNT_W = 10;
	localparam int unsigned STT_P_SHIFT = 7;
	localparam logic [2:0] STT_ADR_CTRL0 = 3'h0;
	localparam logic [2:0] STT_ADR_CTRL1 = 3'h1;
	localparam logic [2:0] STT_ADR_CNTL = 3'h2;
	localparam logic [2:0] STT_ADR_CNTH = 3'h3;
	localparam logic [2:0] STT_ADR_CCRAL = 3'h4;
	localparam logic [2:0] STT_ADR_CCRAH = 3'h5;
	localparam logic [2:0] STT_ADR_STAT = 3'h6;
	localparam logic [7:0] STT_CTRL0_RST = 8'h00;
	localparam logic [7:0] STT_CTRL1_RST = 8'h00;
	localparam logic [9:0] STT_CNT_RST = 10'h000;
	localparam logic [9:0] STT_CNT_MAX = 10'h3ff;
	localparam logic [9:0] STT_COMPARE_A_VALUE_RST = 10'h000;
	localparam int unsigned STT_C0_PAU = 7;
	localparam int unsigned STT_C0_CK_LSB = 4;
	localparam int unsigned STT_C0_ON = 3;
	localparam int unsigned STT_C0_RP_LSB = 0;
	localparam int unsigned STT_C1_M_LSB = 6;
	localparam int unsigned STT_C1_IO_LSB = 4;
	localparam int unsigned STT_C1_OC = 3;
	localparam int unsigned STT_C1_POL = 2;
	localparam int unsigned STT_C1_DPX = 1;
	localparam int unsigned STT_C1_CCLR = 0;
	localparam int unsigned STT_ST_AF = 0;
	localparam int unsigned STT_ST_PF = 1;
	localparam logic [2:0] STT_CK_SYS4 = 3'h0;
	localparam logic [2:0] STT_CK_SYS = 3'h1;
	localparam logic [2:0] STT_CK_HS16 = 3'h2;
	localparam logic [2:0] STT_CK_HS64 = 3'h3;
	localparam logic [2:0] STT_CK_TBC = 3'h4;
	localparam logic [2:0] STT_CK_NONE = 3'h5;
	localparam logic [2:0] STT_CK_EXTR = 3'h6;
	localparam logic [2:0] STT_CK_EXTF = 3'h7;
	localparam logic [1:0] STT_M_CMP = 2'h0;
	localparam logic [1:0] STT_M_CAP = 2'h1;
	localparam logic [1:0] STT_M_PWM = 2'h2;
	localparam logic [1:0] STT_M_TC = 2'h3;
	localparam logic [1:0] STT_DIV4_LAST = 2'h3;
	localparam logic [5:0] STT_HS16_MASK = 6'h0f;
	localparam logic [5:0] STT_HS64_MASK = 6'h3f;
endpackage : stt_pkg

// [design/stt_sync.sv]
// two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/10ps
module stt_sync
	import stt_pkg::*;
#(
	parameter int unsigned WIDTH = 2
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	initial begin
		if (WIDTH < 1) $error("stt_sync needs at least one bit");
	end

	// the first stage feeds only the second stage
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule : stt_sync

// [design/stt_clk_sel.sv]
// counter clock source selection and internal prescalers
`timescale 1ns/10ps
module stt_clk_sel
	import stt_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [2:0] clock_select_i,
	input wire logic high_speed_tick_i,
	input wire logic time_base_tick_i,
	input wire logic ext_rise_i,
	input wire logic ext_fall_i,
	output logic tick_o
);
	logic [1:0] div4_r;
	logic [5:0] hs_cnt_r;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			div4_r <= 2'h0;
		end else begin
			div4_r <= div4_r + 2'h1;
		end
	end

	// one prescaler serves both high clock divisions
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hs_cnt_r <= 6'h00;
		end else if (high_speed_tick_i) begin
			hs_cnt_r <= hs_cnt_r + 6'h01;
		end
	end

	always_comb begin
		unique case (clock_select_i)
			STT_CK_SYS4: tick_o = (div4_r == STT_DIV4_LAST);
			STT_CK_SYS: tick_o = 1'b1;
			STT_CK_HS16: tick_o = high_speed_tick_i && ((hs_cnt_r & STT_HS16_MASK) == STT_HS16_MASK);
			STT_CK_HS64: tick_o = high_speed_tick_i && (hs_cnt_r == STT_HS64_MASK);
			STT_CK_TBC: tick_o = time_base_tick_i;
			STT_CK_NONE: tick_o = 1'b0;
			STT_CK_EXTR: tick_o = ext_rise_i;
			STT_CK_EXTF: tick_o = ext_fall_i;
		endcase
	end
endmodule : stt_clk_sel

// [verif/stt_pin_model.sv]
// far-side pins: external count clock bursts, capture level, output pin sampling
`timescale 1ns/10ps
module stt_pin_model (
	input wire logic core_clk_i,
	input wire logic go_i,
	input wire logic [11:0] count_i,
	input wire logic cap_lvl_i,
	input wire logic pin_i,
	output logic ext_clk_o,
	output logic cap_pin_o,
	output logic busy_o,
	output logic [11:0] high_o
);
	logic [11:0] left_r = 12'h000;
	logic [3:0] ph_r = 4'h0;
	logic clk_r = 1'b0;
	logic busy_r = 1'b0;
	logic [11:0] high_r = 12'h000;
	assign cap_pin_o = cap_lvl_i;
	assign ext_clk_o = clk_r;
	assign busy_o = busy_r;
	assign high_o = high_r;
	// clock stands low between bursts; pin sampled just before each rising edge,
	// so every sample shows the settled result of the previous count step
	always @(posedge core_clk_i) begin
		if (go_i) begin
			left_r <= count_i;
			ph_r <= 4'h0;
			high_r <= 12'h000;
			busy_r <= 1'b1;
		end else if (left_r != 12'h000) begin
			ph_r <= (ph_r == 4'hb) ? 4'h0 : ph_r + 4'h1;
			if (ph_r == 4'h0) begin
				clk_r <= 1'b1;
				high_r <= high_r + {11'h000, pin_i};
			end
			if (ph_r == 4'h6) clk_r <= 1'b0;
			if (ph_r == 4'hb) left_r <= left_r - 12'h001;
		end else begin
			busy_r <= 1'b0;
		end
	end
endmodule : stt_pin_model

// [verif/tb_top.sv]
// self-checking bench for the standard ten-bit timer
`timescale 1ns/10ps
module tb_top
	import stt_pkg::*;
;
	localparam int GAP [6] = '{38, 18, 62, 126, 38, 38};
	localparam int CKX [6] = '{10, 20, 2, 1, 20, 0};
	localparam int CAPF [4] = '{1, 1, 2, 0};
	localparam logic [7:0] CM_C1 [7] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h19, 8'h29, 8'h35};
	localparam int CM_IN [7] = '{0, 0, 0, 0, 1, 1, 1};
	localparam int CM_ED [7] = '{0, 0, 1, 11, 1, 0, 11};
	localparam logic [7:0] PW_C1 [7] = '{8'ha9, 8'ha8, 8'haa, 8'h88, 8'h98, 8'h9c, 8'hb8};
	localparam int PW_CA [7] = '{64, 200, 200, 64, 64, 64, 10};
	localparam int PW_N [7] = '{256, 256, 400, 128, 128, 128, 64};
	localparam int PW_HI [7] = '{128, 256, 256, 0, 128, 0, 10};
	localparam int PW_A [7] = '{2, 0, 2, 1, 1, 1, -1};
	localparam int PW_P [7] = '{2, 2, 2, 1, 1, 1, -1};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tb_tick = 1'b0;
	logic cap = 1'b0;
	logic go = 1'b0;
	logic [11:0] cnt = 12'h000;
	logic [7:0] rdata;
	logic ext_pin, cap_pin, pin_o, pin_oe, pwr, af, pf, busy;
	logic [11:0] hi;
	logic pin_q = 1'b0;
	int bad_count = 0;
	int tests_run = 0;
	int af_n = 0;
	int pf_n = 0;
	int ed_n = 0;
	int a0, p0, e0;

	stt_timer dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .high_speed_clock_tick_i(!tb_tick),
		.time_base_clock_tick_i(tb_tick), .external_clock_pin_i(ext_pin),
		.timer_io_pin_i(cap_pin), .timer_io_pin_o(pin_o), .timer_io_pin_oe_o(pin_oe),
		.timer_powered_o(pwr), .compare_a_flag_o(af), .compare_p_flag_o(pf));
	stt_pin_model partner (.core_clk_i(clk), .go_i(go), .count_i(cnt), .cap_lvl_i(cap),
		.pin_i(pin_o), .ext_clk_o(ext_pin), .cap_pin_o(cap_pin), .busy_o(busy), .high_o(hi));

	always #10 clk = ~clk;
	// time-base enable every second cycle gives an exact half-rate count;
	// high-speed enable runs in the other phase so its prescaler gating is exercised
	always @(posedge clk) begin
		tb_tick <= ~tb_tick;
		if (af === 1'b1) af_n <= af_n + 1;
		if (pf === 1'b1) pf_n <= pf_n + 1;
		if (pin_o !== pin_q) ed_n <= ed_n + 1;
		pin_q <= pin_o;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		tests_run++;
		if (g !== e) begin
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
			bad_count++;
		end
	endtask : chk

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk) begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
		end
		@(posedge clk) wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk) begin
			addr <= a;
			rd <= 1'b1;
		end
		@(posedge clk) rd <= 1'b0;
		@(negedge clk) v = rdata;
	endtask : reg_read

	// timer goes off before mode or output function change
	task automatic cfg(input logic [7:0] c1, input logic [9:0] ca, input logic [7:0] c0);
		reg_write(STT_ADR_CTRL0, 8'h00);
		reg_write(STT_ADR_CTRL1, c1);
		reg_write(STT_ADR_CCRAL, ca[7:0]);
		reg_write(STT_ADR_CCRAH, {6'h00, ca[9:8]});
		reg_write(STT_ADR_CTRL0, c0);
		repeat (4) @(posedge clk);
	endtask : cfg

	// read strobes land k+2 cycles apart
	task automatic cdiff(input int k, output logic [7:0] d);
		logic [7:0] v0, v1;
		reg_read(STT_ADR_CNTL, v0);
		repeat (k) @(posedge clk);
		reg_read(STT_ADR_CNTL, v1);
		d = v1 - v0;
	endtask : cdiff

	task automatic run(input int nt);
		int i;
		a0 = af_n;
		p0 = pf_n;
		e0 = ed_n;
		@(posedge clk) begin
			go <= 1'b1;
			cnt <= nt[11:0];
		end
		@(posedge clk) go <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 14000 && busy !== 1'b0; i++) @(posedge clk);
		if (i == 14000) begin
			$display("ERROR partner_busy expected 0 seen 1");
			bad_count++;
			final_report();
		end
		repeat (12) @(posedge clk);
	endtask : run

	initial begin
		logic [7:0] v, w;
		int i;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		reg_write(3'h7, 8'hff);
		for (i = 0; i < 8; i++) begin
			reg_read(i[2:0], v);
			chk("reset_read", 0, v);
		end
		for (i = 0; i < 6; i++) begin
			cfg(8'hc0, 10'h000, {1'b0, i[2:0], 4'h8});
			cdiff(GAP[i], v);
			chk("tick_count", CKX[i], v);
		end
		cfg(8'hc0, 10'h000, 8'h18);
		cdiff(18, v);
		chk("run_count", 20, v);
		reg_write(STT_ADR_CTRL0, 8'h10);
		cdiff(18, v);
		chk("off_hold", 0, v);
		chk("off_power", 0, pwr);
		reg_read(STT_ADR_CNTL, v);
		reg_write(STT_ADR_CNTL, 8'h00);
		reg_read(STT_ADR_CNTL, w);
		chk("cnt_readonly", v, w);
		reg_write(STT_ADR_CTRL0, 8'h18);
		reg_read(STT_ADR_CNTL, v);
		chk("on_clears", 1, v);
		reg_write(STT_ADR_CTRL0, 8'h98);
		cdiff(18, v);
		chk("pause_hold", 0, v);
		chk("pause_power", 1, pwr);
		reg_read(STT_ADR_CNTL, w);
		reg_write(STT_ADR_CTRL0, 8'h18);
		reg_read(STT_ADR_CNTL, v);
		chk("resume", 1, v >= w && v < w + 8);
		for (i = 6; i < 8; i++) begin
			cfg(8'hc0, 10'h000, {1'b0, i[2:0], 4'h8});
			run(7);
			reg_read(STT_ADR_CNTL, v);
			chk("pin_count", 7, v);
		end
		for (i = 0; i < 4; i++) begin
			cfg({2'b01, i[1:0], 4'h0}, 10'h000, 8'h68);
			run(7);
			a0 = af_n;
			cap <= 1'b1;
			repeat (8) @(posedge clk);
			cap <= 1'b0;
			repeat (8) @(posedge clk);
			chk("cap_flags", CAPF[i], af_n - a0);
			reg_read(STT_ADR_CCRAL, v);
			chk("cap_value", (i == 3) ? 0 : 7, v);
			chk("cap_oe", 0, pin_oe);
		end
		for (i = 0; i < 7; i++) begin
			cfg(CM_C1[i], 10'h005, 8'h68);
			chk("cmp_init", CM_IN[i], pin_o);
			chk("cmp_oe", 1, pin_oe);
			run(55);
			chk("cmp_a", 11, af_n - a0);
			chk("cmp_p", 0, pf_n - p0);
			chk("cmp_edges", CM_ED[i], ed_n - e0);
			reg_write(STT_ADR_CTRL0, 8'h60);
			reg_write(STT_ADR_CTRL0, 8'h68);
			repeat (4) @(posedge clk);
			chk("cmp_restore", CM_IN[i], pin_o);
		end
		cfg(8'hc1, 10'h005, 8'h68);
		chk("tc_oe", 0, pin_oe);
		run(10);
		chk("tc_a", 2, af_n - a0);
		cfg(8'h30, 10'h005, 8'h69);
		run(256);
		chk("per_a", 2, af_n - a0);
		chk("per_p", 2, pf_n - p0);
		reg_read(STT_ADR_STAT, v);
		chk("stat_sticky", 3, v);
		reg_write(STT_ADR_STAT, 8'h01);
		reg_read(STT_ADR_STAT, v);
		chk("stat_clear_a", 2, v);
		cfg(8'h30, 10'h005, 8'h68);
		run(1024);
		chk("ovf_p", 1, pf_n - p0);
		reg_read(STT_ADR_CNTH, v);
		reg_read(STT_ADR_CNTL, w);
		chk("ovf_cnt", 0, {v, w});
		for (i = 0; i < 7; i++) begin
			cfg(PW_C1[i], PW_CA[i][9:0], 8'h69);
			run(PW_N[i]);
			chk("pwm_high", PW_HI[i], hi);
			chk("pwm_oe", 1, pin_oe);
			if (PW_A[i] >= 0) begin
				chk("pwm_a", PW_A[i], af_n - a0);
				chk("pwm_p", PW_P[i], pf_n - p0);
			end
		end
		final_report();
	end
endmodule : tb_top
